/* spi_front_map.svh */
// Purpose: constants for the serial flash front end
// Assumes: included by bare name
// Notes: definitions only
`ifndef SPI_FRONT_MAP_SVH
`define SPI_FRONT_MAP_SVH
`define BITS_PER_UNIT 4'h8
`define BIT_CNT_LAST 3'h7
`define BP_WIDTH 3
`define OPC_DUAL_OUT_READ 8'h3b
`define OPC_QUAD_OUT_READ 8'h6b
`define OPC_DUAL_IO_READ 8'hbb
`define OPC_QUAD_IO_READ 8'heb
`define OPC_QUAD_PAGE_PROG 8'h32
`define OPC_PAGE_PROG 8'h02
`define OPC_SECTOR_ERASE 8'hd8
`define OPC_BULK_ERASE 8'hc7
`endif

/* spi_front_pkg.sv */
// Purpose: shared types for the serial flash front end
// Assumes: nothing
// Notes: lane width modes and pin bundles
package spi_front_pkg;
   typedef enum logic [1:0] {
      lane_single = 2'b00,
      lane_dual = 2'b01,
      lane_quad = 2'b10
   } lane_mode_type;
   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } lane_drive_type;
endpackage

/* sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock mclk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync2
   import spi_front_pkg::*;
#(
   parameter int width = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);
   logic [width-1:0] meta_reg;
   logic [width-1:0] meta_next;
   logic [width-1:0] q_next;
   always_comb begin
      meta_next = d;
      q_next = meta_reg;
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= meta_next;
         q <= q_next;
      end
   end
endmodule

/* spi_flash_serial_front_end.sv */
// Operation
// [RL1] output data shifts out on falling serial clock edges
// [RL2] instruction, address and write data captured on rising edges
// [RL3] chip select high deselects and floats the output line
// [RL4] chip select low makes the device active
// [RL5] standby only when deselected and no internal write busy
// [RL6] after reset traffic ignored until a chip select falling edge
// [RL7] hold low floats output, ignores input and clock, keeps state
// [RL8] master uses hold only while chip select is low
// [RL9] protect pin low rejects program or erase into protected area
// [RL10] dual and quad transfers sample lane one as input
// [RL11] dual and quad reads drive lane zero as output
// [RL12] quad transfers drive lanes two and three as outputs; code drives them only when tx_read_phase is set
// [RL13] works in mode 0 or mode 3, same edges
// [RL14] master parks clock low in mode 0, high in mode 3
// [RL15] traffic moves in whole eight-bit units
// [RL16] clock may stop any time while selected
// [RL17] board holds protect and hold pins at defined levels
// [RL18] quad bit reuses protect and hold pins as lanes
// [RL19] frame starts with msb-first opcode; chip select high resets counter
//
// Purpose: pin-level serial front end of a multi-lane flash
// Assumes: serial clock far slower than mclk, sampled as plain input
// Notes: parallel byte stream to and from the core; core owns commands
`timescale 1ns/1ps
`include "spi_front_map.svh"
module spi_flash_serial_front_end
   import spi_front_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in_lane0_i,
   output logic serial_in_lane0_o,
   output logic serial_in_lane0_oe,
   input wire logic serial_out_lane1_i,
   output logic serial_out_lane1_o,
   output logic serial_out_lane1_oe,
   input wire logic protect_n_lane2_i,
   output logic protect_n_lane2_o,
   output logic protect_n_lane2_oe,
   input wire logic pause_n_lane3_i,
   output logic pause_n_lane3_o,
   output logic pause_n_lane3_oe,
   input wire logic quad_enable,
   input wire logic [`BP_WIDTH-1:0] block_protect_field,
   input wire logic target_protected,
   input wire logic write_busy,
   input wire logic [7:0] tx_byte,
   input wire logic tx_read_phase,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic rx_is_opcode,
   output logic tx_taken,
   output logic active,
   output logic standby,
   output logic write_reject
);
   logic [4:0] pins_raw;
   logic [4:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic [3:0] lane_in_s;

   assign pins_raw = {sclk, cs_n, pause_n_lane3_i, protect_n_lane2_i, serial_out_lane1_i};
   // serial clock and pins are asynchronous to mclk
   sync2 #(.width(5)) u_sync_pins (
      .mclk(mclk),
      .nrst(nrst),
      .d(pins_raw),
      .q(pins_s)
   );
   sync2 #(.width(1)) u_sync_si (
      .mclk(mclk),
      .nrst(nrst),
      .d(serial_in_lane0_i),
      .q(lane_in_s[0])
   );
   assign sclk_s = pins_s[4];
   assign cs_n_s = pins_s[3];
   assign lane_in_s[3] = pins_s[2];
   assign lane_in_s[2] = pins_s[1];
   assign lane_in_s[1] = pins_s[0];

   logic sclk_d_reg, sclk_d_next;
   logic cs_n_d_reg, cs_n_d_next;
   logic armed_reg, armed_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_sh_reg, tx_sh_next;
   logic first_reg, first_next;
   logic [7:0] opcode_reg, opcode_next;
   lane_mode_type mode_reg, mode_next;
   lane_drive_type drv_reg, drv_next;
   logic [7:0] rx_byte_next;
   logic rx_valid_next, rx_is_opcode_next, tx_taken_next;
   logic active_next, standby_next, write_reject_next;
   logic paused;
   logic rise, fall, cs_fall;
   logic selected;
   logic [2:0] step;
   logic [7:0] shifted;
   logic prog_or_erase;

   always_comb begin
      // pause pin loses its meaning in quad setup
      paused = !quad_enable && !lane_in_s[3]; // see [RL18]
      selected = !cs_n_s && armed_reg;
      // hold freezes clock edges without dropping the frame
      rise = sclk_s && !sclk_d_reg && selected && !paused; // see [RL7] see [RL13]
      fall = !sclk_s && sclk_d_reg && selected && !paused; // see [RL13] see [RL16]
      cs_fall = !cs_n_s && cs_n_d_reg;
      step = 3'h1;
      if (!first_reg && mode_reg == lane_dual) begin
         step = 3'h2;
      end else if (!first_reg && mode_reg == lane_quad) begin
         step = 3'h4;
      end
      unique case (mode_reg)
         lane_dual: shifted = {shift_reg[5:0], lane_in_s[1:0]}; // see [RL10]
         lane_quad: shifted = {shift_reg[3:0], lane_in_s}; // see [RL10]
         default: shifted = {shift_reg[6:0], lane_in_s[0]}; // see [RL2]
      endcase
      prog_or_erase = 1'b0;
      unique case (shifted)
         `OPC_PAGE_PROG, `OPC_QUAD_PAGE_PROG, `OPC_SECTOR_ERASE, `OPC_BULK_ERASE: begin
            prog_or_erase = 1'b1;
         end
         default: begin
            prog_or_erase = 1'b0;
         end
      endcase
   end

   always_comb begin
      sclk_d_next = sclk_s;
      cs_n_d_next = cs_n_s;
      armed_next = armed_reg || cs_fall; // see [RL6]
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      tx_sh_next = tx_sh_reg;
      first_next = first_reg;
      opcode_next = opcode_reg;
      mode_next = mode_reg;
      drv_next = drv_reg;
      rx_byte_next = rx_byte;
      rx_valid_next = 1'b0;
      rx_is_opcode_next = rx_is_opcode;
      tx_taken_next = 1'b0;
      write_reject_next = write_reject;
      active_next = !cs_n_s && armed_next; // see [RL4]
      standby_next = cs_n_s && !write_busy; // see [RL5]
      if (cs_n_s) begin
         // deselect ends frame and returns to single lane
         bit_cnt_next = 3'h0; // see [RL19]
         first_next = 1'b1;
         mode_next = lane_single;
         drv_next = '0; // see [RL3]
         tx_sh_next = tx_byte;
      end else if (paused) begin
         drv_next.oe = '0; // see [RL7]
      end else if (rise) begin
         shift_next = shifted; // see [RL19]
         bit_cnt_next = 3'(bit_cnt_reg + step);
         if (3'(bit_cnt_reg + step) == 3'h0 || bit_cnt_reg + {1'b0, step} > {1'b0, `BIT_CNT_LAST}) begin
            // whole byte done
            rx_byte_next = shifted; // see [RL15]
            rx_valid_next = 1'b1;
            rx_is_opcode_next = first_reg;
            tx_taken_next = 1'b1;
            tx_sh_next = tx_byte;
            bit_cnt_next = 3'h0;
            if (first_reg) begin
               first_next = 1'b0;
               opcode_next = shifted;
               write_reject_next = 1'b0;
               unique case (shifted)
                  `OPC_DUAL_OUT_READ, `OPC_DUAL_IO_READ: begin
                     mode_next = lane_dual;
                  end
                  `OPC_QUAD_OUT_READ, `OPC_QUAD_IO_READ, `OPC_QUAD_PAGE_PROG: begin
                     // upper lanes are protect and pause pins unless the quad bit is set
                     mode_next = quad_enable ? lane_quad : lane_single; // see [RL18]
                  end
                  default: begin
                     mode_next = lane_single;
                  end
               endcase
               if (prog_or_erase && !quad_enable && !lane_in_s[2] && target_protected
                   && block_protect_field != '0) begin
                  write_reject_next = 1'b1; // see [RL9]
               end
            end
         end
      end else if (fall) begin
         drv_next.oe = '0;
         drv_next.o = '0;
         if (tx_read_phase && !first_reg) begin
            unique case (mode_reg)
               lane_dual: begin
                  drv_next.o[1:0] = tx_sh_reg[7:6]; // see [RL11]
                  drv_next.oe[1:0] = 2'b11;
                  tx_sh_next = {tx_sh_reg[5:0], 2'b00};
               end
               lane_quad: begin
                  drv_next.o = tx_sh_reg[7:4]; // see [RL12]
                  drv_next.oe = 4'hf;
                  tx_sh_next = {tx_sh_reg[3:0], 4'h0};
               end
               default: begin
                  drv_next.o[1] = tx_sh_reg[7]; // see [RL1]
                  drv_next.oe[1] = 1'b1;
                  tx_sh_next = {tx_sh_reg[6:0], 1'b0};
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sclk_d_reg <= 1'b0;
         // same as synchroniser reset, else a false select edge arms us
         cs_n_d_reg <= 1'b0;
         armed_reg <= 1'b0;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         tx_sh_reg <= 8'h00;
         first_reg <= 1'b1;
         opcode_reg <= 8'h00;
         mode_reg <= lane_single;
         drv_reg <= '0;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
         rx_is_opcode <= 1'b0;
         tx_taken <= 1'b0;
         active <= 1'b0;
         standby <= 1'b0;
         write_reject <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_d_next;
         cs_n_d_reg <= cs_n_d_next;
         armed_reg <= armed_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         tx_sh_reg <= tx_sh_next;
         first_reg <= first_next;
         opcode_reg <= opcode_next;
         mode_reg <= mode_next;
         drv_reg <= drv_next;
         rx_byte <= rx_byte_next;
         rx_valid <= rx_valid_next;
         rx_is_opcode <= rx_is_opcode_next;
         tx_taken <= tx_taken_next;
         active <= active_next;
         standby <= standby_next;
         write_reject <= write_reject_next;
      end
   end

   // lane drivers come straight from drv_reg flops
   always_comb begin
      serial_in_lane0_o = drv_reg.o[0];
      serial_in_lane0_oe = drv_reg.oe[0];
      serial_out_lane1_o = drv_reg.o[1];
      serial_out_lane1_oe = drv_reg.oe[1];
      protect_n_lane2_o = drv_reg.o[2];
      protect_n_lane2_oe = drv_reg.oe[2];
      pause_n_lane3_o = drv_reg.o[3];
      pause_n_lane3_oe = drv_reg.oe[3];
   end
endmodule

/* spi_front_checker.sv */
// Purpose: port assertions for the front end
// Assumes: sclk far slower than mclk
// Notes: bound below the module
`timescale 1ns/1ps
module spi_front_checker
   import spi_front_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_in_lane0_oe,
   input wire logic serial_out_lane1_o,
   input wire logic serial_out_lane1_oe,
   input wire logic protect_n_lane2_oe,
   input wire logic pause_n_lane3_i,
   input wire logic pause_n_lane3_oe,
   input wire logic quad_enable,
   input wire logic write_busy,
   input wire logic rx_valid,
   input wire logic rx_is_opcode,
   input wire logic tx_taken,
   input wire logic active,
   input wire logic standby
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_cs_float: assert property (cs_n [*4] |-> !serial_out_lane1_oe && !serial_in_lane0_oe)
      else $error("lane driven while deselected");
   a_sel_active: assert property ($fell(cs_n) ##1 !cs_n [*5] |-> active)
      else $error("not active when selected");
   a_busy_wake: assert property (write_busy |=> !standby)
      else $error("standby while busy");
   a_idle_standby: assert property ((cs_n && !write_busy) [*4] |-> standby)
      else $error("no standby when idle");
   a_byte_pulse: assert property (rx_valid |-> tx_taken ##1 !rx_valid)
      else $error("byte pulse malformed");
   a_rise_capture: assert property (rx_valid |-> sclk && !cs_n)
      else $error("byte done off rising edge");
   a_fall_launch: assert property (serial_out_lane1_oe && $changed(serial_out_lane1_o) |-> !sclk)
      else $error("output moved with clock high");
   a_hold_float: assert property ((!quad_enable && !pause_n_lane3_i) [*4] |-> !serial_out_lane1_oe)
      else $error("output driven in pause");
   a_quad_lanes: assert property (!quad_enable [*3] |-> !protect_n_lane2_oe && !pause_n_lane3_oe)
      else $error("upper lanes driven outside quad");
   c_opcode: cover property (rx_valid && rx_is_opcode);
   c_quad: cover property (pause_n_lane3_oe);
   c_dual: cover property (serial_in_lane0_oe);
endmodule
bind spi_flash_serial_front_end spi_front_checker chk_i (.*);

/* spi_master_model.sv */
// Purpose: spi bus master model
// Assumes: called at falling mclk, half period 8 mclk
// Notes: the bench resolves lane levels
`timescale 1ns/1ps
module spi_master_model (
   input wire logic mclk,
   input wire logic [3:0] lanes,
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   output logic mosi_en,
   output logic [7:0] rd
);
   logic m3;
   initial begin
      {m3, sclk, cs_n, mosi} = 4'h0; // low from power-up, no fall yet
      mosi_en = 1'b1;
      rd = 8'h00;
   end
   task automatic half();
      repeat (8) @(negedge mclk);
   endtask
   task automatic open_frame(input logic mode3);
      m3 = mode3;
      sclk = mode3; // idle level of the mode
      half();
      cs_n = 1'b0;
      half();
   endtask
   task automatic close_frame();
      sclk = m3;
      half();
      cs_n = 1'b1;
      half();
   endtask
   // msb first, w lanes per edge
   task automatic shift(input logic [7:0] b, input int n, input int w);
      for (int k = 0; k < n; k += w) begin
         sclk = 1'b0;
         mosi_en = (w == 1);
         mosi = b[7-k];
         half();
         sclk = 1'b1;
         rd = w == 4 ? {rd[3:0], lanes} : w == 2 ? {rd[5:0], lanes[1:0]} : {rd[6:0], lanes[1]};
         half();
      end
   endtask
endmodule

/* spi_flash_serial_front_end_tb_top.sv */
// Purpose: self-checking bench for the front end
// Assumes: master model at 80 ns sclk
// Notes: byte notes queued and checked by a monitor
`timescale 1ns/1ps
`include "spi_front_map.svh"
module spi_flash_serial_front_end_tb_top
   import spi_front_pkg::*;
;
   logic mclk = 1'b0, nrst = 1'b0, tog = 1'b0, protect_n = 1'b1, pause_n = 1'b1, quad_enable = 1'b0;
   logic target_protected = 1'b0, write_busy = 1'b0, tx_read_phase = 1'b0, sclk, cs_n, mosi, mosi_en;
   logic serial_in_lane0_o, serial_in_lane0_oe, serial_out_lane1_o, serial_out_lane1_oe, protect_n_lane2_o;
   logic protect_n_lane2_oe, pause_n_lane3_o, pause_n_lane3_oe, rx_valid, rx_is_opcode, standby, write_reject;
   logic [2:0] block_protect_field = 3'h1;
   logic [7:0] tx_byte = 8'h00, rx_byte, rd;
   logic [31:0] seed = 32'h37793893;
   logic [8:0] notes[$];
   logic [7:0] rops[3] = '{8'h03, `OPC_DUAL_OUT_READ, `OPC_QUAD_OUT_READ};
   int failures = 0, compares = 0;
   // released lanes 0 and 1 show a changing pattern, not the last level; lanes 2 and 3 show protect_n and pause_n
   wire logic serial_in_lane0_i = serial_in_lane0_oe ? serial_in_lane0_o : mosi_en ? mosi : tog;
   wire logic serial_out_lane1_i = serial_out_lane1_oe ? serial_out_lane1_o : tog;
   wire logic protect_n_lane2_i = protect_n_lane2_oe ? protect_n_lane2_o : protect_n;
   wire logic pause_n_lane3_i = pause_n_lane3_oe ? pause_n_lane3_o : pause_n;
   spi_master_model m (.mclk(mclk), .lanes({pause_n_lane3_i, protect_n_lane2_i, serial_out_lane1_i, serial_in_lane0_i}),
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .mosi_en(mosi_en), .rd(rd));
   spi_flash_serial_front_end uut (.*, .tx_taken(), .active());
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic send(input logic [7:0] b, input logic op);
      notes.push_back({op, b});
      m.shift(b, 8, 1);
   endtask
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) tog <= ~tog;
   // read data bytes carry no note
   always @(negedge mclk) if (rx_valid === 1'b1 && !(tx_read_phase && rx_is_opcode !== 1'b1)) begin
      if (notes.size() == 0) chk({2'b11, rx_byte}, 10'h000);
      else chk({1'b0, rx_is_opcode, rx_byte}, {1'b0, notes.pop_front()});
   end
   initial begin
      repeat (12) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      m.shift(8'ha5, 8, 1);
      m.close_frame();
      $display("test unarmed done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         write_busy = i[0];
         m.open_frame(i[1]);
         send({3'b100, seed[20:16]}, 1'b1);
         send(seed[7:0], 1'b0);
         notes.push_back({1'b0, seed[15:8]});
         m.shift(seed[15:8], 4, 1);
         pause_n = 1'b0;
         m.shift(~seed[15:8], 4, 1);
         pause_n = 1'b1;
         repeat (40) @(negedge mclk);
         m.shift({seed[11:8], 4'h0}, 4, 1);
         m.close_frame();
      end
      $display("test frames done");
      quad_enable = 1'b1;
      tx_read_phase = 1'b1;
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         tx_byte = seed[7:0];
         m.open_frame(i[0]);
         send(rops[i], 1'b1);
         m.shift(8'h00, 8, 1 << i);
         chk({2'b00, rd}, {2'b00, tx_byte});
         m.close_frame();
      end
      $display("test reads done");
      quad_enable = 1'b0;
      tx_read_phase = 1'b0;
      for (int i = 0; i < 5; i++) begin
         protect_n = (i == 3);
         block_protect_field = (i == 4) ? 3'h0 : 3'h1;
         target_protected = (i != 1);
         m.open_frame(1'b0);
         send((i == 1) ? `OPC_SECTOR_ERASE : (i == 2) ? `OPC_BULK_ERASE : `OPC_PAGE_PROG, 1'b1);
         chk({9'h0, write_reject}, {9'h0, (i == 0 || i == 2)});
         m.close_frame();
      end
      $display("test protect done");
      for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge mclk);
      chk(10'(notes.size()), 10'h000);
      summarize();
   end
endmodule
